// *** verilog/mgmt_pkg.sv ***
package mgmt_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_NS = 10000;
   localparam int TICK_CYCLES = (TICK_NS / CLK_PERIOD_NS < 1) ? 1 : TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 16;
   localparam int TIME_W = 20;
   localparam int DUTY_W = 16;
   localparam int DUTY_HALF_DEFAULT = 1000;

   // register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_TEST_CFG = 8'h04;
   localparam logic [7:0] ADDR_ATTR_ID = 8'h08;
   localparam logic [7:0] ADDR_CONFIRM = 8'h0C;
   localparam logic [7:0] ADDR_CNF_DATA = 8'h10;
   localparam logic [7:0] ADDR_ZC_TIME = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // field positions
   localparam int CMD_LSB = 0;
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_DUTY_BIT = 1;
   localparam int CFG_MOD_LSB = 4;
   localparam int CFG_PWR_LSB = 8;
   localparam int CNF_RES_LSB = 0;
   localparam int CNF_KIND_LSB = 4;
   localparam int CNF_BUSY_BIT = 8;
   localparam int STAT_MODE_LSB = 0;

   // result codes
   localparam logic [1:0] RES_OK = 2'h0;
   localparam logic [1:0] RES_FAIL = 2'h1;
   localparam logic [1:0] RES_ALREADY = 2'h2;
   localparam logic [1:0] RES_BAD_ATTR = 2'h2;

   // modulation codes that select nothing, and attenuation per power step
   localparam logic [2:0] MOD_UNUSED_LO = 3'h3;
   localparam logic [2:0] MOD_UNUSED_HI = 3'h7;
   localparam logic [4:0] DB_PER_STEP = 5'h03;

   // attribute identifiers
   localparam logic [7:0] ATTR_PHY_MODE = 8'h00;
   localparam logic [7:0] ATTR_TEST_CFG = 8'h01;
   localparam logic [7:0] ATTR_ZC_TIME = 8'h02;

   typedef enum logic [2:0] {
      CMD_REINIT = 3'h0,
      CMD_SUSPEND = 3'h1,
      CMD_WAKE = 3'h2,
      CMD_TEST = 3'h3,
      CMD_ATTR_READ = 3'h4,
      CMD_ZC_QUERY = 3'h5
   } cmd_e;

   typedef enum logic [1:0] {
      PM_INIT = 2'b00,
      PM_NORMAL = 2'b01,
      PM_SLEEP = 2'b11,
      PM_TEST = 2'b10
   } phy_mode_e;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_DRAIN = 2'b01,
      HS_INIT = 2'b11
   } hs_e;

   typedef struct packed {
      logic enable;
      logic duty;
      logic [2:0] modulation;
      logic [2:0] pwr_level;
   } test_cfg_s;

   typedef struct packed {
      logic valid;
      cmd_e kind;
      logic [1:0] result;
      logic [DATA_W-1:0] data;
   } confirm_s;
endpackage

// *** verilog/zc_timestamp.sv ***
`timescale 1ns/10ps
module zc_timestamp (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic zc_pin,
   output logic [mgmt_pkg::TIME_W-1:0] zc_time
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic [mgmt_pkg::TICK_W-1:0] tick;
      logic [mgmt_pkg::TIME_W-1:0] now;
      logic [mgmt_pkg::TIME_W-1:0] stamp;
   } zc_s;

   zc_s s_reg;
   zc_s s_next;

   localparam logic [mgmt_pkg::TICK_W-1:0] TICK_LAST =
      mgmt_pkg::TICK_W'(mgmt_pkg::TICK_CYCLES - 1);

   always_comb begin
      s_next = s_reg;
      s_next.sync1 = zc_pin;
      s_next.sync2 = s_reg.sync1;
      s_next.prev = s_reg.sync2;
      // time base in units of ten microseconds, wraps at its width
      if (s_reg.tick == TICK_LAST) begin
         s_next.tick = '0;
         s_next.now = s_reg.now + 1'b1;
      end else begin
         s_next.tick = s_reg.tick + 1'b1;
      end
      // stamp the latest rising crossing
      if (s_reg.sync2 && !s_reg.prev) begin
         s_next.stamp = s_reg.now;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign zc_time = s_reg.stamp;

   chk_zc_stamp_capture: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.sync2 && !s_reg.prev) |=> (zc_time == $past(s_reg.now)))
      else $error("zero-cross stamp not captured");
endmodule

// *** verilog/mgmt_cmd_handler.sv ***
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module mgmt_cmd_handler #(
   parameter int DUTY_HALF = mgmt_pkg::DUTY_HALF_DEFAULT
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [mgmt_pkg::ADDR_W-1:0] ADDR,
   input wire logic [mgmt_pkg::DATA_W-1:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [mgmt_pkg::DATA_W-1:0] RDATA,
   input wire logic TX_PENDING,
   input wire logic HW_FAULT,
   input wire logic ZC_PIN,
   output logic FLUSH,
   output logic RX_ENABLE,
   output logic TX_ENABLE,
   output logic TEST_TX_ON,
   output logic [2:0] TEST_MODULATION,
   output logic [4:0] TEST_ATTEN_DB,
   output mgmt_pkg::phy_mode_e PHY_MODE,
   output mgmt_pkg::confirm_s CNF
);
   typedef struct packed {
      mgmt_pkg::hs_e hs;
      mgmt_pkg::phy_mode_e mode;
      mgmt_pkg::cmd_e cmd;
      mgmt_pkg::test_cfg_s cfg_pend;
      mgmt_pkg::test_cfg_s cfg_act;
      logic [7:0] attr_id;
      mgmt_pkg::confirm_s cnf;
      logic [mgmt_pkg::DATA_W-1:0] rdata;
      logic flush;
      logic [mgmt_pkg::DUTY_W-1:0] duty_cnt;
      logic duty_on;
      logic tx_on;
      logic [4:0] atten;
   } ctl_s;

   ctl_s s_reg;
   ctl_s s_next;
   logic [mgmt_pkg::TIME_W-1:0] zc_time;
   logic launch;
   mgmt_pkg::cmd_e req;

   localparam logic [mgmt_pkg::DUTY_W-1:0] DUTY_LAST = mgmt_pkg::DUTY_W'(DUTY_HALF - 1);

   zc_timestamp u_zc (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .zc_pin(ZC_PIN),
      .zc_time(zc_time)
   );

   function automatic mgmt_pkg::confirm_s reply(input mgmt_pkg::cmd_e kind,
      input logic [1:0] res, input logic [mgmt_pkg::DATA_W-1:0] data);
      mgmt_pkg::confirm_s c;
      c.valid = 1'b1;
      c.kind = kind;
      c.result = res;
      c.data = data;
      return c;
   endfunction

   function automatic logic mod_unused(input logic [2:0] m);
      return (m == mgmt_pkg::MOD_UNUSED_LO) || (m == mgmt_pkg::MOD_UNUSED_HI);
   endfunction

   // a command is taken only when no earlier one awaits its confirm
   assign launch = WR_STB && (ADDR == mgmt_pkg::ADDR_CMD) && (s_reg.hs == mgmt_pkg::HS_IDLE);
   assign req = mgmt_pkg::cmd_e'(WDATA[mgmt_pkg::CMD_LSB +: 3]);

   always_comb begin
      s_next = s_reg;
      s_next.cnf.valid = 1'b0;
      s_next.flush = 1'b0;
      s_next.rdata = '0;
      // register reads, answered in the next cycle
      if (RD_STB) begin
         unique case (ADDR)
            mgmt_pkg::ADDR_TEST_CFG: begin
               s_next.rdata[mgmt_pkg::CFG_EN_BIT] = s_reg.cfg_pend.enable;
               s_next.rdata[mgmt_pkg::CFG_DUTY_BIT] = s_reg.cfg_pend.duty;
               s_next.rdata[mgmt_pkg::CFG_MOD_LSB +: 3] = s_reg.cfg_pend.modulation;
               s_next.rdata[mgmt_pkg::CFG_PWR_LSB +: 3] = s_reg.cfg_pend.pwr_level;
            end
            mgmt_pkg::ADDR_ATTR_ID: s_next.rdata[7:0] = s_reg.attr_id;
            mgmt_pkg::ADDR_CONFIRM: begin
               s_next.rdata[mgmt_pkg::CNF_RES_LSB +: 2] = s_reg.cnf.result;
               s_next.rdata[mgmt_pkg::CNF_KIND_LSB +: 3] = s_reg.cnf.kind;
               s_next.rdata[mgmt_pkg::CNF_BUSY_BIT] = (s_reg.hs != mgmt_pkg::HS_IDLE);
            end
            mgmt_pkg::ADDR_CNF_DATA: s_next.rdata = s_reg.cnf.data;
            mgmt_pkg::ADDR_ZC_TIME: s_next.rdata[mgmt_pkg::TIME_W-1:0] = zc_time;
            mgmt_pkg::ADDR_STATUS: s_next.rdata[mgmt_pkg::STAT_MODE_LSB +: 2] = s_reg.mode;
            default: s_next.rdata = '0;
         endcase
      end
      // configuration writes
      if (WR_STB && ADDR == mgmt_pkg::ADDR_TEST_CFG) begin
         s_next.cfg_pend.enable = WDATA[mgmt_pkg::CFG_EN_BIT];
         s_next.cfg_pend.duty = WDATA[mgmt_pkg::CFG_DUTY_BIT];
         s_next.cfg_pend.modulation = WDATA[mgmt_pkg::CFG_MOD_LSB +: 3];
         s_next.cfg_pend.pwr_level = WDATA[mgmt_pkg::CFG_PWR_LSB +: 3];
      end
      if (WR_STB && ADDR == mgmt_pkg::ADDR_ATTR_ID) begin
         s_next.attr_id = WDATA[7:0];
      end
      // command sequencing; every path ends in one confirm
      unique case (s_reg.hs)
         mgmt_pkg::HS_IDLE: begin
            if (launch) begin
               s_next.cmd = req;
               unique case (req)
                  mgmt_pkg::CMD_REINIT: begin
                     if (HW_FAULT) begin
                        s_next.cnf = reply(req, mgmt_pkg::RES_FAIL, '0);
                     end else begin
                        s_next.flush = 1'b1;
                        s_next.mode = mgmt_pkg::PM_INIT;
                        s_next.cfg_act = '0;
                        s_next.duty_cnt = '0;
                        s_next.hs = mgmt_pkg::HS_INIT;
                     end
                  end
                  mgmt_pkg::CMD_SUSPEND: begin
                     if (s_reg.mode == mgmt_pkg::PM_SLEEP) begin
                        s_next.cnf = reply(req, mgmt_pkg::RES_ALREADY, '0);
                     end else if (HW_FAULT) begin
                        s_next.cnf = reply(req, mgmt_pkg::RES_FAIL, '0);
                     end else if (TX_PENDING) begin
                        s_next.hs = mgmt_pkg::HS_DRAIN;
                     end else begin
                        s_next.mode = mgmt_pkg::PM_SLEEP;
                        s_next.cnf = reply(req, mgmt_pkg::RES_OK, '0);
                     end
                  end
                  mgmt_pkg::CMD_WAKE: begin
                     if (s_reg.mode != mgmt_pkg::PM_SLEEP) begin
                        s_next.cnf = reply(req, mgmt_pkg::RES_ALREADY, '0);
                     end else if (HW_FAULT) begin
                        s_next.cnf = reply(req, mgmt_pkg::RES_FAIL, '0);
                     end else begin
                        s_next.mode = mgmt_pkg::PM_NORMAL;
                        s_next.cnf = reply(req, mgmt_pkg::RES_OK, '0);
                     end
                  end
                  mgmt_pkg::CMD_TEST: begin
                     if (!s_reg.cfg_pend.enable) begin
                        if (s_reg.mode == mgmt_pkg::PM_TEST) begin
                           s_next.mode = mgmt_pkg::PM_NORMAL;
                        end
                        s_next.cnf = reply(req, mgmt_pkg::RES_OK, '0);
                     end else if (s_reg.mode == mgmt_pkg::PM_TEST) begin
                        s_next.cnf = reply(req, mgmt_pkg::RES_ALREADY, '0);
                     end else if (HW_FAULT || s_reg.mode == mgmt_pkg::PM_SLEEP
                        || mod_unused(s_reg.cfg_pend.modulation)) begin
                        s_next.cnf = reply(req, mgmt_pkg::RES_FAIL, '0);
                     end else begin
                        s_next.cfg_act = s_reg.cfg_pend;
                        s_next.duty_cnt = '0;
                        if (TX_PENDING) begin
                           s_next.hs = mgmt_pkg::HS_DRAIN;
                        end else begin
                           s_next.mode = mgmt_pkg::PM_TEST;
                           s_next.cnf = reply(req, mgmt_pkg::RES_OK, '0);
                        end
                     end
                  end
                  mgmt_pkg::CMD_ATTR_READ: begin
                     unique case (s_reg.attr_id)
                        mgmt_pkg::ATTR_PHY_MODE:
                           s_next.cnf = reply(req, mgmt_pkg::RES_OK,
                              mgmt_pkg::DATA_W'(s_reg.mode));
                        mgmt_pkg::ATTR_TEST_CFG:
                           s_next.cnf = reply(req, mgmt_pkg::RES_OK,
                              mgmt_pkg::DATA_W'(s_reg.cfg_act));
                        mgmt_pkg::ATTR_ZC_TIME:
                           s_next.cnf = reply(req, mgmt_pkg::RES_OK,
                              mgmt_pkg::DATA_W'(zc_time));
                        default:
                           s_next.cnf = reply(req, mgmt_pkg::RES_BAD_ATTR, '0);
                     endcase
                  end
                  mgmt_pkg::CMD_ZC_QUERY: begin
                     s_next.cnf = reply(req, mgmt_pkg::RES_OK,
                        mgmt_pkg::DATA_W'(zc_time));
                  end
                  default: begin
                     s_next.cmd = mgmt_pkg::CMD_ATTR_READ;
                     s_next.cnf = reply(mgmt_pkg::CMD_ATTR_READ, mgmt_pkg::RES_BAD_ATTR, '0);
                  end
               endcase
            end
         end
         mgmt_pkg::HS_DRAIN: begin
            // hold the confirm until the queue has drained
            if (!TX_PENDING) begin
               s_next.mode = (s_reg.cmd == mgmt_pkg::CMD_SUSPEND) ?
                  mgmt_pkg::PM_SLEEP : mgmt_pkg::PM_TEST;
               s_next.cnf = reply(s_reg.cmd, mgmt_pkg::RES_OK, '0);
               s_next.hs = mgmt_pkg::HS_IDLE;
            end
         end
         mgmt_pkg::HS_INIT: begin
            s_next.mode = mgmt_pkg::PM_NORMAL;
            s_next.cnf = reply(mgmt_pkg::CMD_REINIT, mgmt_pkg::RES_OK, '0);
            s_next.hs = mgmt_pkg::HS_IDLE;
         end
         default: s_next.hs = mgmt_pkg::HS_IDLE;
      endcase
      // half-period toggle for the duty-cycled test transmit
      if (s_reg.mode == mgmt_pkg::PM_TEST && s_reg.cfg_act.duty) begin
         if (s_reg.duty_cnt == DUTY_LAST) begin
            s_next.duty_cnt = '0;
            s_next.duty_on = !s_reg.duty_on;
         end else begin
            s_next.duty_cnt = s_reg.duty_cnt + 1'b1;
         end
      end else begin
         s_next.duty_on = 1'b1;
      end
      s_next.tx_on = (s_next.mode == mgmt_pkg::PM_TEST)
         && (!s_next.cfg_act.duty || s_next.duty_on);
      s_next.atten = 5'(s_next.cfg_act.pwr_level * mgmt_pkg::DB_PER_STEP);
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign RDATA = s_reg.rdata;
   assign FLUSH = s_reg.flush;
   assign PHY_MODE = s_reg.mode;
   // sleep and init stop both directions; test stops reception
   assign RX_ENABLE = (s_reg.mode == mgmt_pkg::PM_NORMAL);
   assign TX_ENABLE = (s_reg.mode == mgmt_pkg::PM_NORMAL) || (s_reg.mode == mgmt_pkg::PM_TEST);
   assign TEST_TX_ON = s_reg.tx_on;
   assign TEST_MODULATION = s_reg.cfg_act.modulation;
   assign TEST_ATTEN_DB = s_reg.atten;
   assign CNF = s_reg.cnf;

   chk_cnf_single_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (CNF.valid && !launch) |=> !CNF.valid)
      else $error("confirm valid longer than one cycle");

   chk_reinit_flush_init: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_REINIT && !HW_FAULT)
      |=> FLUSH && PHY_MODE == mgmt_pkg::PM_INIT && !CNF.valid
      ##1 CNF.valid && CNF.kind == mgmt_pkg::CMD_REINIT && CNF.result == mgmt_pkg::RES_OK
      && PHY_MODE == mgmt_pkg::PM_NORMAL)
      else $error("reinit sequence wrong");

   chk_reinit_fail: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_REINIT && HW_FAULT)
      |=> CNF.valid && CNF.result == mgmt_pkg::RES_FAIL && !FLUSH)
      else $error("failed reinit not reported");

   chk_sleep_silent: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (PHY_MODE == mgmt_pkg::PM_SLEEP) |-> !RX_ENABLE && !TX_ENABLE && !TEST_TX_ON)
      else $error("activity while asleep");

   chk_sleep_already: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_SUSPEND && PHY_MODE == mgmt_pkg::PM_SLEEP)
      |=> CNF.valid && CNF.kind == mgmt_pkg::CMD_SUSPEND && CNF.result == mgmt_pkg::RES_ALREADY)
      else $error("already-asleep code wrong");

   chk_wake_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_WAKE && PHY_MODE == mgmt_pkg::PM_SLEEP && !HW_FAULT)
      |=> CNF.valid && CNF.result == mgmt_pkg::RES_OK && RX_ENABLE && TX_ENABLE)
      else $error("wake did not restart");

   chk_wake_already: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_WAKE && PHY_MODE != mgmt_pkg::PM_SLEEP)
      |=> CNF.valid && CNF.result == mgmt_pkg::RES_ALREADY && $stable(PHY_MODE))
      else $error("wake code wrong when awake");

   chk_drain_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (s_reg.hs == mgmt_pkg::HS_DRAIN && TX_PENDING)
      |=> !CNF.valid && $stable(PHY_MODE))
      else $error("confirm before drain finished");

   chk_test_already: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_TEST && s_reg.cfg_pend.enable
      && PHY_MODE == mgmt_pkg::PM_TEST)
      |=> CNF.valid && CNF.result == mgmt_pkg::RES_ALREADY)
      else $error("already-test code wrong");

   chk_test_exit: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_TEST && !s_reg.cfg_pend.enable
      && PHY_MODE == mgmt_pkg::PM_TEST)
      |=> PHY_MODE == mgmt_pkg::PM_NORMAL && CNF.valid && !TEST_TX_ON)
      else $error("test exit wrong");

   chk_test_continuous: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (PHY_MODE == mgmt_pkg::PM_TEST && !s_reg.cfg_act.duty) [*2] |-> TEST_TX_ON)
      else $error("continuous transmit dropped");

   chk_atten_scale: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      TEST_ATTEN_DB == (5'(s_reg.cfg_act.pwr_level) << 1) + 5'(s_reg.cfg_act.pwr_level))
      else $error("attenuation not 3 dB per step");

   chk_attr_bad: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_ATTR_READ && s_reg.attr_id > mgmt_pkg::ATTR_ZC_TIME)
      |=> CNF.valid && CNF.kind == mgmt_pkg::CMD_ATTR_READ
      && CNF.result == mgmt_pkg::RES_BAD_ATTR)
      else $error("unsupported attribute not flagged");

   chk_zc_reply: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (launch && req == mgmt_pkg::CMD_ZC_QUERY)
      |=> CNF.valid && CNF.data == mgmt_pkg::DATA_W'($past(zc_time)))
      else $error("zero-cross reply wrong");
endmodule

// *** bench/tx_queue_model.sv ***
`timescale 1ns/10ps
module tx_queue_model (
   input wire logic clk,
   input wire logic load,
   input wire logic [7:0] len,
   input wire logic flush,
   output logic pending
);
   logic [7:0] cnt_reg = 8'h00;
   // one queued frame leaves per cycle; a flush throws the queue away
   always_ff @(posedge clk) begin
      if (flush) begin
         cnt_reg <= 8'h00;
      end else if (load) begin
         cnt_reg <= len;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
   assign pending = (cnt_reg != 8'h00);
endmodule

// *** bench/tb_mgmt_cmd_handler.sv ***
`timescale 1ns/10ps
module tb_mgmt_cmd_handler;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0;
   logic HW_FAULT = 1'b0, ZC_PIN = 1'b0, load = 1'b0;
   logic [7:0] ADDR = 8'h00, len = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA, d;
   logic TX_PENDING, FLUSH, RX_ENABLE, TX_ENABLE, TEST_TX_ON;
   logic [2:0] TEST_MODULATION;
   logic [4:0] TEST_ATTEN_DB;
   mgmt_pkg::phy_mode_e PHY_MODE;
   mgmt_pkg::confirm_s CNF;
   int fails = 0, comparisons = 0, cyc = 0, ncmd = 0, ncnf = 0, nfl = 0;
   int md = 0, ten = 0, tmo = 0, aid = 0, pw, n, t;
   mgmt_cmd_handler #(.DUTY_HALF(4)) mgmt_cmd_handler_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
      .TX_PENDING(TX_PENDING), .HW_FAULT(HW_FAULT), .ZC_PIN(ZC_PIN), .FLUSH(FLUSH),
      .RX_ENABLE(RX_ENABLE), .TX_ENABLE(TX_ENABLE), .TEST_TX_ON(TEST_TX_ON),
      .TEST_MODULATION(TEST_MODULATION), .TEST_ATTEN_DB(TEST_ATTEN_DB),
      .PHY_MODE(PHY_MODE), .CNF(CNF));
   tx_queue_model tx_queue_model_i (.clk(SYS_CLK), .load(load), .len(len), .flush(FLUSH),
      .pending(TX_PENDING));
   always #10 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (CNF.valid === 1'b1) ncnf <= ncnf + 1;
      if (FLUSH === 1'b1) nfl <= nfl + 1;
      if (cyc >= 20000) begin
         fails = fails + 1;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= v;
      WR_STB <= 1'b1;
      @(posedge SYS_CLK);
      WR_STB <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge SYS_CLK);
      RD_STB <= 1'b0;
      #1;
      v = RDATA;
   endtask
   task automatic ld(input int k);
      @(posedge SYS_CLK);
      load <= 1'b1;
      len <= k[7:0];
      @(posedge SYS_CLK);
      load <= 1'b0;
   endtask
   task automatic cfg(input int en, input int du, input int mo, input int p);
      ten = en;
      tmo = mo;
      wr(mgmt_pkg::ADDR_TEST_CFG, {21'h0, p[2:0], 1'b0, mo[2:0], 2'h0, du[0], en[0]});
   endtask
   // reference behaviour of the handler; md tracks the expected mode
   function automatic int model(input int c, input int f);
      case (c)
         0: if (f) return 1; else begin md = 1; return 0; end
         1: if (md == 3) return 2; else if (f) return 1; else begin md = 3; return 0; end
         2: if (md != 3) return 2; else if (f) return 1; else begin md = 1; return 0; end
         3: if (ten == 0) begin if (md == 2) md = 1; return 0; end
            else if (md == 2) return 2;
            else if (f || md == 3 || tmo == 3 || tmo == 7) return 1;
            else begin md = 2; return 0; end
         4: return (aid < 3) ? 0 : 2;
         5: return 0;
         default: return 2;
      endcase
   endfunction
   task automatic cmd(input int c, input int poke);
      int r;
      int k;
      wr(mgmt_pkg::ADDR_CMD, c);
      r = model(c, HW_FAULT);
      if (poke) wr(mgmt_pkg::ADDR_CMD, 32'h2);
      k = 0;
      while (CNF.valid !== 1'b1 && k < 400) begin
         @(posedge SYS_CLK);
         #1;
         k++;
      end
      ncmd++;
      check("confirm", k < 400, 1);
      check("kind", CNF.kind, (c < 6) ? c : 4);
      check("result", CNF.result, r);
      check("mode", PHY_MODE, md);
      check("rx_en", RX_ENABLE, md == 1);
      check("tx_en", TX_ENABLE, md == 1 || md == 2);
      check("pending", TX_PENDING, 0);
   endtask
   initial begin
      pw = $urandom(32'h1FDE);
      repeat (20) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      rd(mgmt_pkg::ADDR_STATUS, d);
      check("status", d, 0);
      rd(8'hFC, d);
      check("unmapped", d, 0);
      ld(60);
      cmd(0, 0);
      check("flush", nfl, 1);
      ld($urandom % 40 + 5);
      cmd(1, 1);
      cmd(1, 0);
      HW_FAULT <= 1'b1;
      cmd(2, 0);
      HW_FAULT <= 1'b0;
      cmd(2, 0);
      cmd(2, 0);
      HW_FAULT <= 1'b1;
      cmd(1, 0);
      cmd(0, 0);
      HW_FAULT <= 1'b0;
      for (int mo = 0; mo < 8; mo++) begin
         pw = $urandom % 8;
         cfg(1, mo % 2, mo, pw);
         if (mo == 2) ld(25);
         cmd(3, 0);
         if (md == 2) begin
            check("mod", TEST_MODULATION, mo);
            check("atten", TEST_ATTEN_DB, 3 * pw);
            n = 0;
            repeat (16) begin
               @(posedge SYS_CLK);
               #1;
               if (TEST_TX_ON === 1'b1) n++;
            end
            check("duty", n, (mo % 2) ? 8 : 16);
            cmd(3, 0);
         end
         cfg(0, 0, mo, pw);
         cmd(3, 0);
      end
      for (aid = 0; aid < 4; aid++) begin
         wr(mgmt_pkg::ADDR_ATTR_ID, aid);
         cmd(4, 0);
         if (aid == 0) check("attr_mode", CNF.data, md);
         if (aid == 3) check("attr_none", CNF.data, 0);
      end
      cmd(6, 0);
      rd(mgmt_pkg::ADDR_CONFIRM, d);
      check("cnf_reg", d, 32'h42);
      repeat (1500) @(posedge SYS_CLK);
      ZC_PIN <= 1'b1;
      t = (cyc - 21) / 500;
      repeat (10) @(posedge SYS_CLK);
      ZC_PIN <= 1'b0;
      cmd(5, 0);
      check("zc", CNF.data + 1 >= t && CNF.data <= t + 1, 1);
      repeat (3) @(posedge SYS_CLK);
      check("confirms", ncnf, ncmd);
      print_verdict();
   end
endmodule
